/* rio_pkg.sv */
// Constants for the relay discrete I/O operand block
// Summary of operation
// RL1: Thirty-two command-driven virtual input channels.
// RL2: Virtual operands read low until commanded.
// RL3: Virtual input states survive a power loss.
// RL4: Disabled channel stays low, ignores commands.
// RL5: Self-reset mode pulses high one pass.
// RL6: Latched mode follows the most recent command.
// RL7: Select timer deselects inputs when expired.
// RL8: Contact energized by operate or hold operand.
// RL9: Contact state change logs an event.
// RL10: Trip current present and absent flags.
// RL11: Read bistable positions before any evaluation.
// RL12: Position mismatch raises fault, event, target; code raises fault and event only, no target.
// RL13: Close drive sealed until contact closed.
// RL14: Open drive sealed until contact open.
// RL15: Conflict resolved by operate or reset dominance.
// RL16: All pass behaviour updates on pass strobe; code forces disabled operands low and updates the mismatch fault every clock.
// RL17: Strobe qualifies updates; commands wait for it.
// RL18: Mismatch check waits out coil transit.
package rio_pkg;
    localparam int VI_NUM = 32;
    localparam int IRQ_W  = 6;
    // Register byte offsets
    localparam logic [11:0] RA_VI_EN     = 12'h000;
    localparam logic [11:0] RA_VI_MODE   = 12'h004;
    localparam logic [11:0] RA_VI_CMD    = 12'h008;
    localparam logic [11:0] RA_VI_STATE  = 12'h00C;
    localparam logic [11:0] RA_SBO_SEL   = 12'h010;
    localparam logic [11:0] RA_SBO_TIME  = 12'h014;
    localparam logic [11:0] RA_CO_OPSEL  = 12'h018;
    localparam logic [11:0] RA_CO_HOLD   = 12'h01C;
    localparam logic [11:0] RA_CO_EVT    = 12'h020;
    localparam logic [11:0] RA_LO_CLOSE  = 12'h024;
    localparam logic [11:0] RA_LO_OPEN   = 12'h028;
    localparam logic [11:0] RA_LO_CFG    = 12'h02C;
    localparam logic [11:0] RA_IRQ_STAT  = 12'h030;
    localparam logic [11:0] RA_IRQ_MASK  = 12'h034;
    localparam logic [11:0] RA_IO_STAT   = 12'h038;
    // Field positions
    localparam int SEL_W        = 6;
    localparam int HOLD_EN_BIT  = 7;
    localparam int CFG_TRAN_LSB = 8;
    localparam int IRQ_LERR_BIT = 4;
    localparam int IRQ_SBO_BIT  = 5;
    // Reset values
    localparam logic [7:0] LO_TRANSIT_RST = 8'h10;
    localparam logic [7:0] SBO_TIME_RST   = 8'h40;
    typedef enum logic [0:0] {
        PH_INIT = 1'b0,
        PH_RUN  = 1'b1
    } rio_phase_t;
endpackage

/* rio_operand_ctrl.sv */
// Virtual inputs, contact outputs and latching outputs with APB registers
`timescale 1ns/1ps
module rio_operand_ctrl #(
    parameter int NCO = 4,
    parameter int NLO = 4
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    input  wire logic                     passStrobe,
    input  wire logic [31:0]              extOperand,
    input  wire logic                     nvLoad,
    input  wire logic [31:0]              nvValue,
    input  wire logic [NCO-1:0]           coCurrent,
    input  wire logic [NLO-1:0]           loPosition,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic [rio_pkg::VI_NUM-1:0]    viOperand,
    output logic [31:0]                   nvImage,
    output logic [NCO-1:0]                coEnergize,
    output logic [NCO-1:0]                tripCurrentPresentFlag,
    output logic [NCO-1:0]                tripCurrentAbsentFlag,
    output logic [NLO-1:0]                closeCoil,
    output logic [NLO-1:0]                openCoil,
    output logic                          latchFault,
    output logic                          irq
);
    import rio_pkg::*;

    // Selector fields are one byte each, so at most four of each output
    typedef struct packed {
        rio_phase_t         phase;
        logic [31:0]        viEn;
        logic [31:0]        viLatch;
        logic [31:0]        viCmd;
        logic [31:0]        viRise;
        logic [31:0]        viOp;
        logic [31:0]        sboSel;
        logic [7:0]         sboTime;
        logic [7:0]         sboCnt;
        logic               sboRun;
        logic [31:0]        coOpSel;
        logic [31:0]        coHoldSel;
        logic [NCO-1:0]     coEvtEn;
        logic [NCO-1:0]     coOut;
        logic [NCO-1:0]     curOn;
        logic [NCO-1:0]     curOff;
        logic [31:0]        loCloseSel;
        logic [31:0]        loOpenSel;
        logic [NLO-1:0]     loPrio;
        logic [7:0]         loTransit;
        logic [NLO-1:0]     loCmdPos;
        logic [NLO-1:0]     closeDrv;
        logic [NLO-1:0]     openDrv;
        logic [NLO*8-1:0]   loTimer;
        logic               latchErr;
        logic [IRQ_W-1:0]   irqStat;
        logic [IRQ_W-1:0]   irqMask;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } rio_state_t;

    rio_state_t st;
    rio_state_t nxt;

    logic [63:0]      pool;
    logic             upd;
    logic             acc;
    logic             wrEn;
    logic             hit;
    logic [31:0]      rdVal;
    logic [31:0]      cmdRise;
    logic [IRQ_W-1:0] irqSet;
    logic [NLO-1:0]   mism;
    logic             wantC;
    logic             wantO;
    logic             coNew;
    logic [7:0]       tmr;

    // RL1: thirty-two virtual channels
    assign pool = {extOperand, st.viOp};

    always_comb begin
        nxt     = st;
        irqSet  = '0;
        mism    = '0;
        wantC   = 1'b0;
        wantO   = 1'b0;
        coNew   = 1'b0;
        tmr     = '0;
        cmdRise = '0;
        rdVal   = '0;
        // RL16: pass strobe gating
        upd  = passStrobe && (st.phase == PH_RUN);
        acc  = psel && penable;
        wrEn = acc && st.pready && pwrite;
        hit  = (paddr[1:0] == 2'b00) && (paddr <= RA_IO_STAT);

        // Register read mux
        case (paddr)
            RA_VI_EN:    rdVal = st.viEn;
            RA_VI_MODE:  rdVal = st.viLatch;
            RA_VI_CMD:   rdVal = st.viCmd;
            RA_VI_STATE: rdVal = st.viOp;
            RA_SBO_SEL:  rdVal = st.sboSel;
            RA_SBO_TIME: rdVal = {24'h00_0000, st.sboTime};
            RA_CO_OPSEL: rdVal = st.coOpSel;
            RA_CO_HOLD:  rdVal = st.coHoldSel;
            RA_CO_EVT:   rdVal = 32'(st.coEvtEn);
            RA_LO_CLOSE: rdVal = st.loCloseSel;
            RA_LO_OPEN:  rdVal = st.loOpenSel;
            RA_LO_CFG:   rdVal = 32'(st.loPrio) | {16'h0000, st.loTransit, 8'h00};
            RA_IRQ_STAT: rdVal = 32'(st.irqStat);
            RA_IRQ_MASK: rdVal = 32'(st.irqMask);
            RA_IO_STAT: begin
                rdVal[3:0]   = 4'(st.coOut);
                rdVal[7:4]   = 4'(st.curOn);
                rdVal[11:8]  = 4'(loPosition);
                rdVal[15:12] = 4'(st.loCmdPos);
                rdVal[19:16] = 4'(st.closeDrv);
                rdVal[23:20] = 4'(st.openDrv);
                rdVal[24]    = st.latchErr;
                rdVal[25]    = st.phase;
            end
            default:     rdVal = '0;
        endcase

        // Two-cycle access phase; answer lands when pready rises
        nxt.pready  = acc && !st.pready;
        nxt.pslverr = acc && !st.pready && !hit;
        if (acc && !st.pready && !pwrite) begin
            nxt.prdata = hit ? rdVal : '0;
        end

        // RL11: positions read first
        if (st.phase == PH_INIT) begin
            nxt.loCmdPos = loPosition;
            nxt.phase    = PH_RUN;
        end

        // RL17: rising commands held to strobe
        if (upd) begin
            // RL5: one pass pulse
            // RL6: latched follows command
            nxt.viOp   = st.viEn & ((st.viLatch & st.viCmd) |
                                    (~st.viLatch & st.viRise));
            nxt.viRise = '0;
        end

        if (wrEn) begin
            case (paddr)
                RA_VI_EN:    nxt.viEn = pwdata;
                RA_VI_MODE:  nxt.viLatch = pwdata;
                RA_VI_CMD: begin
                    // RL4: disabled ignores commands
                    nxt.viCmd = (pwdata & st.viEn) | (st.viCmd & ~st.viEn);
                    cmdRise   = pwdata & ~st.viCmd & st.viEn;
                    // RL7: operate starts select timer
                    if (st.sboSel != '0) begin
                        nxt.sboRun = 1'b1;
                        nxt.sboCnt = st.sboTime;
                    end
                end
                RA_SBO_SEL:  nxt.sboSel = st.sboSel | pwdata;
                RA_SBO_TIME: nxt.sboTime = pwdata[7:0];
                RA_CO_OPSEL: nxt.coOpSel = pwdata;
                RA_CO_HOLD:  nxt.coHoldSel = pwdata;
                RA_CO_EVT:   nxt.coEvtEn = pwdata[NCO-1:0];
                RA_LO_CLOSE: nxt.loCloseSel = pwdata;
                RA_LO_OPEN:  nxt.loOpenSel = pwdata;
                RA_LO_CFG: begin
                    nxt.loPrio    = pwdata[NLO-1:0];
                    nxt.loTransit = pwdata[CFG_TRAN_LSB +: 8];
                end
                RA_IRQ_MASK: nxt.irqMask = pwdata[IRQ_W-1:0];
                default:     nxt.irqMask = nxt.irqMask;
            endcase
        end
        // A rise in the strobe cycle stays pending for the next pass
        nxt.viRise = nxt.viRise | cmdRise;

        // RL3: restore retained states
        if (nvLoad) begin
            nxt.viCmd  = nvValue;
            nxt.viRise = '0;
            nxt.viOp   = nvValue & st.viEn & st.viLatch;
        end
        // RL4: disabled channel forced low
        nxt.viOp = nxt.viOp & nxt.viEn;

        // RL7: select expiry deselects
        if (upd && st.sboRun) begin
            if (st.sboCnt == 8'h00) begin
                nxt.sboSel = '0;
                nxt.sboRun = 1'b0;
                irqSet[IRQ_SBO_BIT] = 1'b1;
            end else begin
                nxt.sboCnt = st.sboCnt - 8'h01;
            end
        end

        for (int i = 0; i < NCO; i++) begin
            // RL8: operate or hold-on energizes
            coNew = pool[st.coOpSel[8*i +: SEL_W]] |
                    (st.coHoldSel[8*i+HOLD_EN_BIT] &
                     pool[st.coHoldSel[8*i +: SEL_W]]);
            if (upd) begin
                nxt.coOut[i] = coNew;
                // RL9: change-of-state event
                if (coNew != st.coOut[i] && st.coEvtEn[i]) begin
                    irqSet[i] = 1'b1;
                end
                // RL10: trip current flags
                nxt.curOn[i]  = coCurrent[i];
                nxt.curOff[i] = !coCurrent[i];
            end
        end

        for (int i = 0; i < NLO; i++) begin
            tmr = st.loTimer[8*i +: 8];
            // RL15: dominance resolves conflict
            wantC = pool[st.loCloseSel[8*i +: SEL_W]] &&
                    (!pool[st.loOpenSel[8*i +: SEL_W]] || st.loPrio[i]);
            wantO = pool[st.loOpenSel[8*i +: SEL_W]] &&
                    (!pool[st.loCloseSel[8*i +: SEL_W]] || !st.loPrio[i]);
            if (upd) begin
                if (tmr != 8'h00) begin
                    tmr = tmr - 8'h01;
                end
                if (st.closeDrv[i]) begin
                    // RL13: close drive sealed in
                    if (loPosition[i]) begin
                        nxt.closeDrv[i] = 1'b0;
                    end
                end else if (st.openDrv[i]) begin
                    // RL14: open drive sealed in
                    if (!loPosition[i]) begin
                        nxt.openDrv[i] = 1'b0;
                    end
                end else if (wantC) begin
                    nxt.loCmdPos[i] = 1'b1;
                    if (!loPosition[i]) begin
                        nxt.closeDrv[i] = 1'b1;
                        tmr = st.loTransit;
                    end
                end else if (wantO) begin
                    nxt.loCmdPos[i] = 1'b0;
                    if (loPosition[i]) begin
                        nxt.openDrv[i] = 1'b1;
                        tmr = st.loTransit;
                    end
                end
            end
            nxt.loTimer[8*i +: 8] = tmr;
            // RL18: compare after transit
            mism[i] = (st.phase == PH_RUN) && (st.loTimer[8*i +: 8] == 8'h00) &&
                      (st.loCmdPos[i] != loPosition[i]);
        end

        // RL12: mismatch fault and event
        nxt.latchErr = |mism;
        if ((|mism) && !st.latchErr) begin
            irqSet[IRQ_LERR_BIT] = 1'b1;
        end

        // Set wins over a write-one clear in the same cycle
        if (wrEn && paddr == RA_IRQ_STAT) begin
            nxt.irqStat = st.irqStat & ~pwdata[IRQ_W-1:0];
        end
        nxt.irqStat = nxt.irqStat | irqSet;
        nxt.irq     = |(nxt.irqStat & nxt.irqMask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st           <= '0;
            st.loTransit <= LO_TRANSIT_RST;
            st.sboTime   <= SBO_TIME_RST;
        end else if (ce) begin
            st <= nxt;
        end
    end

    assign prdata                 = st.prdata;
    assign pready                 = st.pready;
    assign pslverr                = st.pslverr;
    // RL2: operands reset low
    assign viOperand              = st.viOp;
    assign nvImage                = st.viCmd;
    assign coEnergize             = st.coOut;
    assign tripCurrentPresentFlag = st.curOn;
    assign tripCurrentAbsentFlag  = st.curOff;
    assign closeCoil              = st.closeDrv;
    assign openCoil               = st.openDrv;
    assign latchFault             = st.latchErr;
    assign irq                    = st.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    disabled_low_a: assert property ( // RL4
        (viOperand & ~st.viEn) == '0)
        else $error("Disabled virtual input reads high");

    pulse_one_a: assert property ( // RL5
        (ce && upd && !nvLoad) |=>
        ((viOperand & ~$past(st.viLatch) & ~$past(st.viRise)) == '0))
        else $error("Self-reset operand held past one pass");

    latched_follow_a: assert property ( // RL6
        (ce && upd && !nvLoad && !wrEn) |=>
        (((viOperand ^ $past(st.viCmd)) & st.viEn & $past(st.viLatch)) == '0))
        else $error("Latched operand differs from command");

    init_quiet_a: assert property ( // RL11
        (st.phase == PH_INIT) |-> (closeCoil == '0 && openCoil == '0 &&
                                   coEnergize == '0 && !latchFault))
        else $error("Outputs moved before positions were read");

    close_seal_a: assert property ( // RL13
        (closeCoil[0] && !loPosition[0]) |=> closeCoil[0])
        else $error("Close drive dropped before contact closed");

    open_seal_a: assert property ( // RL14
        (openCoil[0] && loPosition[0]) |=> openCoil[0])
        else $error("Open drive dropped before contact opened");

    conflict_prio_a: assert property ( // RL15
        (ce && upd && !st.closeDrv[1] && !st.openDrv[1] && st.loPrio[1] && !loPosition[1]
         && pool[st.loCloseSel[8 +: SEL_W]] && pool[st.loOpenSel[8 +: SEL_W]]) |=> closeCoil[1])
        else $error("Conflict not resolved toward close");

    reset_dom_a: assert property ( // RL15
        (ce && upd && !st.closeDrv[0] && !st.openDrv[0] && !st.loPrio[0] && loPosition[0]
         && pool[st.loCloseSel[0 +: SEL_W]] && pool[st.loOpenSel[0 +: SEL_W]]) |=> openCoil[0])
        else $error("Conflict not resolved toward open");

    mismatch_flag_a: assert property ( // RL12
        (ce && (|mism)) |=> (latchFault && st.irqStat[IRQ_LERR_BIT]))
        else $error("Position mismatch not flagged");

    contact_drive_a: assert property ( // RL8
        (ce && upd && pool[st.coOpSel[0 +: SEL_W]]) |=> coEnergize[0])
        else $error("Contact not energized by its operand");

    contact_event_a: assert property ( // RL9
        (ce && upd && st.coEvtEn[0] && (st.coOut[0] != (pool[st.coOpSel[0 +: SEL_W]] |
         (st.coHoldSel[HOLD_EN_BIT] & pool[st.coHoldSel[0 +: SEL_W]])))) |=> st.irqStat[0])
        else $error("Contact change not logged");

    trip_flags_a: assert property ( // RL10
        (ce && upd) |=> (tripCurrentPresentFlag == $past(coCurrent) &&
                         tripCurrentAbsentFlag == ~$past(coCurrent)))
        else $error("Trip current flags wrong");

    transit_wait_a: assert property ( // RL18
        $rose(closeCoil[0]) |-> (st.loTimer[7:0] == $past(st.loTransit)))
        else $error("Mismatch check not delayed by transit");

    irq_level_a: assert property (
        irq == |(st.irqStat & st.irqMask))
        else $error("Interrupt output disagrees with status");

endmodule

/* rio_contact_model.sv */
// Behavioural bistable contacts and trip-circuit current detectors
`timescale 1ns/1ps
module rio_contact_model #(
    parameter int         NCO  = 4,
    parameter int         NLO  = 4,
    parameter int         MOVE = 6,
    parameter logic [3:0] INIT = 4'h0
) (
    input  wire logic           clk,
    input  wire logic [NCO-1:0] coEnergize,
    input  wire logic [NLO-1:0] closeCoil,
    input  wire logic [NLO-1:0] openCoil,
    input  wire logic           stuck,
    output logic      [NCO-1:0] coCurrent,
    output logic      [NLO-1:0] loPosition
);
    int moveCnt [NLO];
    // Position survives unpowered
    // Bistable contacts keep their place through power loss, so no reset
    initial loPosition = INIT[NLO-1:0];
    initial coCurrent = '0;
    always @(posedge clk) coCurrent <= coEnergize;
    // Coils move contact
    // Stuck freezes every contact so a mismatch can be provoked
    always @(posedge clk) begin
        for (int i = 0; i < NLO; i++) begin
            if ((closeCoil[i] ^ openCoil[i]) && !stuck) begin
                moveCnt[i] <= moveCnt[i] + 1;
                if (moveCnt[i] >= MOVE - 1) loPosition[i] <= closeCoil[i];
            end else begin
                moveCnt[i] <= 0;
            end
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the relay discrete I/O operand block
`timescale 1ns/1ps
module tb;
    import rio_pkg::*;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        passStrobe = 1'b0;
    logic [31:0] extOp = 32'h0000_0000;
    logic        nvLoad = 1'b0;
    logic [31:0] nvValue = 32'h0000_0000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        stuck = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] prdata, viOperand, nvImage;
    logic        pready, pslverr, latchFault, irq;
    logic [3:0]  coEnergize, tripPresent, tripAbsent, closeCoil, openCoil;
    logic [3:0]  coCurrent, loPosition;
    int          errorCnt = 0;
    int          totalChecks = 0;
    int          cycCnt = 0;

    always #4 clk = ~clk;

    rio_operand_ctrl dut (
        .clk(clk), .sys_rst(sysRst), .ce(ce), .passStrobe(passStrobe),
        .extOperand(extOp), .nvLoad(nvLoad), .nvValue(nvValue), .coCurrent(coCurrent),
        .loPosition(loPosition), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .viOperand(viOperand), .nvImage(nvImage),
        .coEnergize(coEnergize), .tripCurrentPresentFlag(tripPresent),
        .tripCurrentAbsentFlag(tripAbsent), .closeCoil(closeCoil), .openCoil(openCoil),
        .latchFault(latchFault), .irq(irq));

    rio_contact_model #(.INIT(4'h4)) model (
        .clk(clk), .coEnergize(coEnergize), .closeCoil(closeCoil), .openCoil(openCoil),
        .stuck(stuck), .coCurrent(coCurrent), .loPosition(loPosition));

    task automatic summarize;
        $display("Checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Run far longer than the sequence needs, then give up
    always @(posedge clk) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 8000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Strobes are spaced so that inputs set beforehand are long settled
    task automatic strobe(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            passStrobe <= 1'b1;
            @(posedge clk);
            passStrobe <= 1'b0;
        end
        @(negedge clk);
    endtask

    task automatic setExt(input logic [31:0] v);
        @(posedge clk);
        extOp <= v;
    endtask

    task automatic testReset;
        logic [31:0] r;
        logic        e;
        chk("viOperand", 32'h0000_0000, viOperand);
        rd(RA_SBO_TIME, r, e);
        chk("sboTimeRst", 32'h0000_0040, r);
        rd(RA_LO_CFG, r, e);
        chk("transitRst", 32'h0000_0010, {24'h0, r[15:8]});
        rd(RA_IO_STAT, r, e);
        chk("ioPosition", 32'h0000_0044, {24'h0, r[15:8]});
        chk("ioPhase", 32'h0000_0002, {30'h0, r[25:24]});
        rd(12'h03C, r, e);
        chk("unmappedErr", 32'h0000_0001, {31'h0, e});
        // Park every selector on an operand held low before any strobe
        wr(RA_CO_OPSEL, 32'h3F3F_3F3F);
        wr(RA_CO_HOLD, 32'h3F3F_3F3F);
        wr(RA_LO_CLOSE, 32'h3F3F_3F3F);
        wr(RA_LO_OPEN, 32'h3F3F_3F3F);
    endtask

    task automatic testVirtual;
        wr(RA_VI_EN, 32'hFFFF_FFFB);
        wr(RA_VI_MODE, 32'hFFFF_FFFE);
        wr(RA_VI_CMD, 32'hFFFF_FFFF);
        idle(2);
        chk("viBeforeStrobe", 32'h0000_0000, viOperand);
        chk("nvImage", 32'hFFFF_FFFB, nvImage);
        strobe(1);
        chk("viFirstPass", 32'hFFFF_FFFB, viOperand);
        strobe(1);
        chk("viSecondPass", 32'hFFFF_FFFA, viOperand);
        wr(RA_VI_EN, 32'h0000_0000);
        idle(2);
        chk("viDisabled", 32'h0000_0000, viOperand);
        wr(RA_VI_CMD, 32'h0000_0005);
        wr(RA_VI_EN, 32'hFFFF_FFFB);
        strobe(1);
        chk("viCmdIgnored", 32'hFFFF_FFFA, viOperand);
        wr(RA_VI_CMD, 32'h0000_0000);
        strobe(1);
        chk("viLatchedLow", 32'h0000_0000, viOperand);
        // A pass while the enable is low must be lost, not deferred
        wr(RA_VI_CMD, 32'h0000_0010);
        ce <= 1'b0;
        strobe(1);
        chk("viFrozen", 32'h0000_0000, viOperand);
        @(posedge clk);
        ce <= 1'b1;
        strobe(1);
        chk("viThawed", 32'h0000_0010, viOperand);
        @(posedge clk);
        nvValue <= 32'h0000_0002;
        nvLoad  <= 1'b1;
        @(posedge clk);
        nvLoad  <= 1'b0;
        strobe(1);
        chk("viRestored", 32'h0000_0002, viOperand);
    endtask

    task automatic testSelect;
        logic [31:0] r;
        logic        e;
        wr(RA_SBO_TIME, 32'h0000_0002);
        wr(RA_SBO_SEL, 32'h0000_0001);
        wr(RA_VI_CMD, 32'h0000_0000);
        strobe(2);
        rd(RA_SBO_SEL, r, e);
        chk("sboHeld", 32'h0000_0001, r);
        strobe(1);
        rd(RA_SBO_SEL, r, e);
        chk("sboExpired", 32'h0000_0000, r);
        rd(RA_IRQ_STAT, r, e);
        chk("sboStatus", 32'h0000_0001, {31'h0, r[IRQ_SBO_BIT]});
        wr(RA_IRQ_MASK, 32'h0000_0000);
        idle(1);
        chk("irqMasked", 32'h0000_0000, {31'h0, irq});
        wr(RA_IRQ_MASK, 32'hFFFF_FFFF);
        idle(1);
        chk("irqUnmasked", 32'h0000_0001, {31'h0, irq});
        wr(RA_IRQ_STAT, 32'h0000_003F);
        idle(1);
        chk("irqCleared", 32'h0000_0000, {31'h0, irq});
    endtask

    task automatic testContacts;
        logic [31:0] r;
        logic        e;
        wr(RA_CO_OPSEL, 32'h3F3F_3F20);
        wr(RA_CO_HOLD, 32'h3F3F_3FA1);
        wr(RA_CO_EVT, 32'h0000_0001);
        setExt(32'h0000_0001);
        strobe(1);
        chk4("coOperate", 4'h1, coEnergize);
        strobe(1);
        chk4("tripPresent", 4'h1, tripPresent);
        chk4("tripAbsent", 4'hE, tripAbsent);
        setExt(32'h0000_0002);
        strobe(1);
        chk4("coHoldOn", 4'h1, coEnergize);
        setExt(32'h0000_0000);
        strobe(1);
        chk4("coReleased", 4'h0, coEnergize);
        rd(RA_IRQ_STAT, r, e);
        chk4("coEvents", 4'h1, r[3:0]);
    endtask

    task automatic testLatching;
        logic [31:0] r;
        logic        e;
        wr(RA_LO_CLOSE, 32'h3F3F_2624);
        wr(RA_LO_OPEN, 32'h3F3F_2725);
        wr(RA_LO_CFG, 32'h0000_0402);
        setExt(32'h0000_0010);
        strobe(1);
        chk4("closeDrive", 4'h1, closeCoil);
        setExt(32'h0000_0000);
        strobe(1);
        chk4("closeSealed", 4'h1, closeCoil);
        strobe(2);
        chk4("closedPos", 4'h5, loPosition);
        chk4("closeDone", 4'h0, closeCoil);
        setExt(32'h0000_0010);
        strobe(1);
        chk4("closeIgnored", 4'h0, closeCoil);
        setExt(32'h0000_00F0);
        strobe(1);
        chk4("conflictClose", 4'h2, closeCoil);
        chk4("conflictOpen", 4'h1, openCoil);
        setExt(32'h0000_0000);
        strobe(3);
        chk4("swappedPos", 4'h6, loPosition);
        setExt(32'h0000_0020);
        strobe(1);
        chk4("openIgnored", 4'h0, openCoil);
        chk("noTransitFault", 32'h0000_0000, {31'h0, latchFault});
        stuck <= 1'b1;
        setExt(32'h0000_0010);
        strobe(2);
        chk("faultWaits", 32'h0000_0000, {31'h0, latchFault});
        strobe(4);
        chk("mismatchFault", 32'h0000_0001, {31'h0, latchFault});
        rd(RA_IRQ_STAT, r, e);
        chk("mismatchEvent", 32'h0000_0001, {31'h0, r[IRQ_LERR_BIT]});
    endtask

    initial begin
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        testReset();
        testVirtual();
        testSelect();
        testContacts();
        testLatching();
        summarize();
    end
endmodule
